// ===== pkg/line_alarm_pkg.sv
package line_alarm_pkg;

	// register offsets
	localparam logic [7:0] OFF_ALARM_STATE   = 8'hb9;
	localparam logic [7:0] OFF_IRQ_ENABLES   = 8'hba;
	localparam logic [7:0] OFF_CHANGE_FLAGS  = 8'hbb;
	localparam logic [7:0] OFF_FL_DECLARE    = 8'hbc; // criteria register in e1 mode
	localparam logic [7:0] OFF_FL_CLEAR      = 8'hbd;
	localparam logic [7:0] OFF_REM_DECLARE   = 8'hbe;
	localparam logic [7:0] OFF_REM_CLEAR     = 8'hbf;
	localparam logic [7:0] OFF_BLUE_DECLARE  = 8'hc0;
	localparam logic [7:0] OFF_BLUE_CLEAR    = 8'hc1;
	localparam logic [7:0] OFF_LINE_CONFIG   = 8'hc2;

	// alarm bit positions in state, flag and enable registers
	localparam int BIT_FRAME_LOSS = 0;
	localparam int BIT_REMOTE     = 1;
	localparam int BIT_BLUE       = 2;
	localparam int BIT_E1_REMOTE  = 3;
	localparam int BIT_MF_REMOTE  = 4;
	localparam int NUM_ALARMS     = 5;

	// criteria register fields (e1 view of 0xbc)
	localparam int BIT_REMOTE_CRIT = 0;
	localparam int BIT_BLUE_CRIT   = 1;

	// line config fields
	localparam int BIT_E1_MODE = 0;
	localparam int FMT_LSB     = 1;

	// reset values
	localparam logic [7:0] RST_LIMIT    = 8'h01;
	localparam logic [4:0] RST_ENABLES  = 5'h00;
	localparam logic [1:0] RST_CRITERIA = 2'h0;
	localparam logic [3:0] RST_CONFIG   = 4'h0;

	// timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int WINDOW_MS     = 40;
	localparam int E1_LOSS_MS    = 100;
	localparam int WINDOW_CYCLES = (CLK_HZ / 1000) * WINDOW_MS;
	localparam int E1_LOSS_CYCLES = (CLK_HZ / 1000) * E1_LOSS_MS;

	// per-window thresholds
	localparam logic [6:0] SLC_MIN_ONES   = 7'h4d; // 77
	localparam logic [3:0] ESF_MAX_PAT    = 4'h7;
	localparam logic [15:0] ESF_PATTERN   = 16'hff00;
	localparam logic [6:0] DM_MIN_ONES    = 7'h04;
	localparam logic [6:0] J1_MIN_ZEROS   = 7'h04;
	localparam logic [6:0] DL_MIN_ZEROS   = 7'h03;
	localparam logic [6:0] BLUE_MIN_ZEROS = 7'h3d; // 61
	localparam logic [8:0] E1_BLUE_LAST   = 9'h1ff; // 512-bit window
	localparam logic [1:0] E1_BLUE_ZEROS  = 2'h3;
	localparam logic [2:0] E1_A_RUN       = 3'h4;
	localparam logic [2:0] E1_Y_RUN       = 3'h3;

	// yellow framing formats
	typedef enum logic [2:0] {
		FMT_SLC96 = 3'h0,
		FMT_ESF   = 3'h1,
		FMT_DM    = 3'h2,
		FMT_J1SF  = 3'h3,
		FMT_DL    = 3'h4
	} yellow_fmt_e;

endpackage

// ===== design/line_alarm_detector.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - any rise or fall of an alarm state sets its change flag.
// - writing one to a change flag clears it; a set flag means pending interrupt.
// - interrupt pin goes low while any enabled change flag is set.
// - t1 frame loss declared after sync loss lasts N windows of 40 ms.
// - slc-96 window is yellow when bit 2 shows fewer than 77 ones.
// - esf window is yellow when more than 7 ff00 patterns arrive on data link.
// - dm window is yellow when the y bit shows fewer than 4 ones.
// - j1 window is yellow when frame-12 f-bit shows fewer than 4 zeros.
// - other data-link format window is yellow with fewer than 3 zeros.
// - remote alarm declared after N yellow windows, cleared after M clear windows.
// - yellow detection only runs while the frame is synchronized.
// - t1 window is blue with fewer than 61 zeros; declared after N windows.
// - e1 criteria zero: 4 ones on a bit declare, one zero clears, in sync.
// - e1 criteria one: a single a bit of one declares, a zero clears.
// - e1 multiframe alarm: 3 y bits of one declare, one zero clears.
// - e1 frame loss declared and cleared after 100 ms of lost or regained sync.
// - e1 blue detection runs whatever the sync state.
// - criteria zero: 512-bit window under 3 zeros while out of sync declares blue.
// - criteria one: two consecutive low windows declare, two high windows clear.
module line_alarm_detector
	import line_alarm_pkg::*;
#(
	parameter int WINDOW_LEN  = WINDOW_CYCLES,
	parameter int E1_LOSS_LEN = E1_LOSS_CYCLES
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	// framer status
	input  wire logic       frame_sync,
	input  wire logic       cas_mf_sync,
	// received data stream
	input  wire logic       rx_bit_valid,
	input  wire logic       rx_bit,
	// yellow monitor bit chosen by framer for the format
	input  wire logic       yel_bit_valid,
	input  wire logic       yel_bit,
	// e1 a bit and multiframe y bit
	input  wire logic       e1_a_valid,
	input  wire logic       e1_a_bit,
	input  wire logic       e1_y_valid,
	input  wire logic       e1_y_bit,
	// alarm outputs
	output logic      [4:0] alarm_state,
	output logic            irq_n
);

	// elaboration checks: both counters are 24 bits wide
	if (WINDOW_LEN < 2 || WINDOW_LEN >= (1 << 24)) begin : g_win_chk
		$error("WINDOW_LEN out of range");
	end
	if (E1_LOSS_LEN < 2 || E1_LOSS_LEN >= (1 << 24)) begin : g_loss_chk
		$error("E1_LOSS_LEN out of range");
	end

	localparam logic [23:0] WIN_LAST  = 24'(WINDOW_LEN - 1);
	localparam logic [23:0] LOSS_LAST = 24'(E1_LOSS_LEN - 1);

	typedef struct packed {
		logic [23:0]     win_cnt;
		logic            seen_sync;
		logic            seen_loss;
		logic [6:0]      yel_ones;
		logic [6:0]      yel_zeros;
		logic [15:0]     dl_shift;
		logic [3:0]      pat_cnt;
		logic [6:0]      blue_zeros;
		logic [7:0]      fl_pers;
		logic [7:0]      rem_pers;
		logic [7:0]      blue_pers;
		logic [23:0]     loss_cnt;
		logic [8:0]      e1_bits;
		logic [1:0]      e1_zeros;
		logic            prev_low;
		logic            prev_high;
		logic [2:0]      a_run;
		logic [2:0]      y_run;
		logic [4:0]      alarms;
		logic [4:0]      flags;
		logic [4:0]      enables;
		logic [5:0][7:0] limits;
		logic [1:0]      criteria;
		logic [3:0]      config_bits;
		logic [7:0]      rd_data;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// persistence step: returns {alarm, count}
	function automatic logic [8:0] persist(input logic alarm, input logic decl_cond,
		input logic clr_cond, input logic [7:0] cnt, input logic [7:0] lim_d,
		input logic [7:0] lim_c);
		logic       cond;
		logic [7:0] lim;
		logic [7:0] inc;
		cond = alarm ? clr_cond : decl_cond;
		lim = alarm ? lim_c : lim_d;
		inc = (cnt == 8'hff) ? cnt : cnt + 8'h01;
		if (!cond)
			persist = {alarm, 8'h00};
		else if (inc >= lim)
			persist = {~alarm, 8'h00};
		else
			persist = {alarm, inc};
	endfunction

	logic        e1_mode;
	logic [2:0]  fmt;
	logic        win_end;
	logic        yel_window;
	logic        clr_window;
	logic        sync_now_seen;
	logic        loss_now_seen;
	logic [15:0] shift_now;
	logic [8:0]  step;
	logic        e1_low;
	logic [1:0]  zeros_now;
	logic [4:0]  new_alarms;
	logic [4:0]  clear_mask;

	assign e1_mode = state_reg.config_bits[BIT_E1_MODE];
	assign fmt     = state_reg.config_bits[FMT_LSB +: 3];
	assign win_end = (state_reg.win_cnt == WIN_LAST);

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_next = state_reg;
		new_alarms = state_reg.alarms;
		clear_mask = 5'h00;
		yel_window = 1'b0;
		clr_window = 1'b0;
		step = 9'h000;
		e1_low = 1'b0;
		zeros_now = state_reg.e1_zeros;
		sync_now_seen = state_reg.seen_sync | frame_sync;
		loss_now_seen = state_reg.seen_loss | ~frame_sync;
		shift_now = state_reg.dl_shift;

		// free-running 40 ms window timer for this link
		state_next.win_cnt = win_end ? 24'h000000 : state_reg.win_cnt + 24'h000001;

		if (!e1_mode) begin
			// sync history over the current window
			state_next.seen_sync = sync_now_seen;
			state_next.seen_loss = loss_now_seen;

			// yellow bit counting, only while in frame sync
			if (yel_bit_valid && frame_sync) begin
				if (yel_bit && state_reg.yel_ones != 7'h7f)
					state_next.yel_ones = state_reg.yel_ones + 7'h01;
				if (!yel_bit && state_reg.yel_zeros != 7'h7f)
					state_next.yel_zeros = state_reg.yel_zeros + 7'h01;
				shift_now = {state_reg.dl_shift[14:0], yel_bit}; // msb first
				state_next.dl_shift = shift_now;
				if (shift_now == ESF_PATTERN && state_reg.pat_cnt != 4'hf)
					state_next.pat_cnt = state_reg.pat_cnt + 4'h1;
			end

			// zero count for blue
			if (rx_bit_valid && !rx_bit && state_reg.blue_zeros != 7'h7f)
				state_next.blue_zeros = state_reg.blue_zeros + 7'h01;

			if (win_end) begin
				// frame loss persistence
				step = persist(state_reg.alarms[BIT_FRAME_LOSS], ~sync_now_seen, ~loss_now_seen,
					state_reg.fl_pers, state_reg.limits[0], state_reg.limits[1]);
				new_alarms[BIT_FRAME_LOSS] = step[8];
				state_next.fl_pers = step[7:0];

				// per-format yellow window verdict
				case (fmt)
					FMT_SLC96: yel_window = state_reg.yel_ones < SLC_MIN_ONES;
					FMT_ESF:   yel_window = state_reg.pat_cnt > ESF_MAX_PAT;
					FMT_DM:    yel_window = state_reg.yel_ones < DM_MIN_ONES;
					FMT_J1SF:  yel_window = state_reg.yel_zeros < J1_MIN_ZEROS;
					FMT_DL:    yel_window = state_reg.yel_zeros < DL_MIN_ZEROS;
					default:   yel_window = 1'b0;
				endcase
				if (frame_sync) begin
					step = persist(state_reg.alarms[BIT_REMOTE], yel_window, ~yel_window,
						state_reg.rem_pers, state_reg.limits[2], state_reg.limits[3]);
					new_alarms[BIT_REMOTE] = step[8];
					state_next.rem_pers = step[7:0];
				end else begin
					state_next.rem_pers = 8'h00;
				end

				// blue persistence
				clr_window = ~(state_reg.blue_zeros < BLUE_MIN_ZEROS);
				step = persist(state_reg.alarms[BIT_BLUE], ~clr_window, clr_window,
					state_reg.blue_pers, state_reg.limits[4], state_reg.limits[5]);
				new_alarms[BIT_BLUE] = step[8];
				state_next.blue_pers = step[7:0];

				// restart window accumulators
				state_next.seen_sync = 1'b0;
				state_next.seen_loss = 1'b0;
				state_next.yel_ones = 7'h00;
				state_next.yel_zeros = 7'h00;
				state_next.pat_cnt = 4'h0;
				state_next.blue_zeros = 7'h00;
			end
			new_alarms[BIT_E1_REMOTE] = 1'b0;
			new_alarms[BIT_MF_REMOTE] = 1'b0;
		end else begin
			// e1 frame loss: 100 ms of disagreement toggles the alarm
			if (frame_sync == state_reg.alarms[BIT_FRAME_LOSS]) begin
				if (state_reg.loss_cnt == LOSS_LAST) begin
					new_alarms[BIT_FRAME_LOSS] = ~state_reg.alarms[BIT_FRAME_LOSS];
					state_next.loss_cnt = 24'h000000;
				end else begin
					state_next.loss_cnt = state_reg.loss_cnt + 24'h000001;
				end
			end else begin
				state_next.loss_cnt = 24'h000000;
			end

			// e1 remote alarm on a bits, basic frame sync only
			if (e1_a_valid && frame_sync) begin
				if (!e1_a_bit) begin
					state_next.a_run = 3'h0;
					new_alarms[BIT_E1_REMOTE] = 1'b0;
				end else if (state_reg.criteria[BIT_REMOTE_CRIT]) begin
					new_alarms[BIT_E1_REMOTE] = 1'b1;
				end else begin
					if (state_reg.a_run != E1_A_RUN)
						state_next.a_run = state_reg.a_run + 3'h1;
					if (state_reg.a_run + 3'h1 >= E1_A_RUN)
						new_alarms[BIT_E1_REMOTE] = 1'b1;
				end
			end

			// multiframe remote alarm on y bits, cas multiframe sync only
			if (e1_y_valid && cas_mf_sync) begin
				if (!e1_y_bit) begin
					state_next.y_run = 3'h0;
					new_alarms[BIT_MF_REMOTE] = 1'b0;
				end else begin
					if (state_reg.y_run != E1_Y_RUN)
						state_next.y_run = state_reg.y_run + 3'h1;
					if (state_reg.y_run + 3'h1 >= E1_Y_RUN)
						new_alarms[BIT_MF_REMOTE] = 1'b1;
				end
			end

			// blue: 512-bit windows, sync gates only the criteria zero declare
			if (rx_bit_valid) begin
				if (!rx_bit && state_reg.e1_zeros != E1_BLUE_ZEROS)
					zeros_now = state_reg.e1_zeros + 2'h1;
				state_next.e1_zeros = zeros_now;
				state_next.e1_bits = state_reg.e1_bits + 9'h001;
				if (state_reg.e1_bits == E1_BLUE_LAST) begin
					e1_low = zeros_now != E1_BLUE_ZEROS;
					if (!state_reg.criteria[BIT_BLUE_CRIT]) begin
						if (e1_low && !frame_sync)
							new_alarms[BIT_BLUE] = 1'b1;
						else if (!e1_low)
							new_alarms[BIT_BLUE] = 1'b0;
					end else begin
						if (e1_low && state_reg.prev_low)
							new_alarms[BIT_BLUE] = 1'b1;
						else if (!e1_low && state_reg.prev_high)
							new_alarms[BIT_BLUE] = 1'b0;
					end
					state_next.prev_low = e1_low;
					state_next.prev_high = ~e1_low;
					state_next.e1_zeros = 2'h0;
				end
			end
			new_alarms[BIT_REMOTE] = 1'b0;
		end
		state_next.alarms = new_alarms;

		// register writes
		if (wr_en) begin
			if (addr == OFF_IRQ_ENABLES)
				state_next.enables = wr_data[4:0];
			else if (addr == OFF_CHANGE_FLAGS)
				clear_mask = wr_data[4:0];
			else if (addr == OFF_FL_DECLARE && e1_mode)
				state_next.criteria = wr_data[1:0];
			else if (addr == OFF_FL_DECLARE)
				state_next.limits[0] = wr_data;
			else if (addr == OFF_FL_CLEAR)
				state_next.limits[1] = wr_data;
			else if (addr == OFF_REM_DECLARE)
				state_next.limits[2] = wr_data;
			else if (addr == OFF_REM_CLEAR)
				state_next.limits[3] = wr_data;
			else if (addr == OFF_BLUE_DECLARE)
				state_next.limits[4] = wr_data;
			else if (addr == OFF_BLUE_CLEAR)
				state_next.limits[5] = wr_data;
			else if (addr == OFF_LINE_CONFIG)
				state_next.config_bits = wr_data[3:0];
		end

		// change flags: a transition wins over a same-cycle clear
		state_next.flags = (state_reg.flags & ~clear_mask) | (new_alarms ^ state_reg.alarms);

		// register reads, data one cycle later
		state_next.rd_data = 8'h00;
		if (rd_en) begin
			if (addr == OFF_ALARM_STATE)
				state_next.rd_data = {3'h0, state_reg.alarms};
			else if (addr == OFF_IRQ_ENABLES)
				state_next.rd_data = {3'h0, state_reg.enables};
			else if (addr == OFF_CHANGE_FLAGS)
				state_next.rd_data = {3'h0, state_reg.flags};
			else if (addr == OFF_FL_DECLARE && e1_mode)
				state_next.rd_data = {6'h00, state_reg.criteria};
			else if (addr == OFF_FL_DECLARE)
				state_next.rd_data = state_reg.limits[0];
			else if (addr == OFF_FL_CLEAR)
				state_next.rd_data = state_reg.limits[1];
			else if (addr == OFF_REM_DECLARE)
				state_next.rd_data = state_reg.limits[2];
			else if (addr == OFF_REM_CLEAR)
				state_next.rd_data = state_reg.limits[3];
			else if (addr == OFF_BLUE_DECLARE)
				state_next.rd_data = state_reg.limits[4];
			else if (addr == OFF_BLUE_CLEAR)
				state_next.rd_data = state_reg.limits[5];
			else if (addr == OFF_LINE_CONFIG)
				state_next.rd_data = {4'h0, state_reg.config_bits};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.limits <= {6{RST_LIMIT}};
			state_reg.enables <= RST_ENABLES;
			state_reg.criteria <= RST_CRITERIA;
			state_reg.config_bits <= RST_CONFIG;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign rd_data     = state_reg.rd_data;
	assign alarm_state = state_reg.alarms;
	assign irq_n       = ~|(state_reg.flags & state_reg.enables);

endmodule

// ===== tb/line_alarm_assertions.sv
`timescale 1ns/1ps
module line_alarm_assertions
	import line_alarm_pkg::*;
#(
	parameter int WINDOW_LEN  = WINDOW_CYCLES,
	parameter int E1_LOSS_LEN = E1_LOSS_CYCLES
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       reset_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rd_data,
	// framer side
	input wire logic       frame_sync,
	input wire logic       cas_mf_sync,
	input wire logic       rx_bit_valid,
	input wire logic       rx_bit,
	input wire logic       yel_bit_valid,
	input wire logic       yel_bit,
	input wire logic       e1_a_valid,
	input wire logic       e1_a_bit,
	input wire logic       e1_y_valid,
	input wire logic       e1_y_bit,
	// alarm outputs
	input wire logic [4:0] alarm_state,
	input wire logic       irq_n
);
	localparam int LOW_MIN = ((WINDOW_LEN < E1_LOSS_LEN) ? WINDOW_LEN : E1_LOSS_LEN) - 1;
	logic [4:0] en_reg;
	logic [4:0] clr_reg;
	logic [4:0] st_reg;
	logic [4:0] fl_reg;
	logic [4:0] fl_next;
	int         low_reg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	// expected flags: old minus clears, plus any state edge
	assign fl_next = (fl_reg & ~clr_reg) | (alarm_state ^ st_reg);
	// shadow of enables, clears, last state and out-of-sync run
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg  <= RST_ENABLES;
			clr_reg <= 5'h00;
			st_reg  <= 5'h00;
			fl_reg  <= 5'h00;
			low_reg <= 0;
		end else begin
			if (wr_en && addr == OFF_IRQ_ENABLES)
				en_reg <= wr_data[4:0];
			clr_reg <= (wr_en && addr == OFF_CHANGE_FLAGS) ? wr_data[4:0] : 5'h00;
			st_reg  <= alarm_state;
			fl_reg  <= fl_next;
			low_reg <= frame_sync ? 0 : low_reg + 1;
		end
	end
	////////////////////////////////////////
	// interrupt pin and register reads
	irq_level_a: assert property (irq_n == !(|(fl_next & en_reg)))
		else $error("irq pin disagrees with flags and enables");
	idle_read_a: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");
	flag_read_a: assert property (rd_en && addr == OFF_CHANGE_FLAGS |=> rd_data == {3'h0, $past(fl_next)})
		else $error("change flags read wrong");
	state_read_a: assert property (rd_en && addr == OFF_ALARM_STATE |=> rd_data == {3'h0, $past(alarm_state)})
		else $error("alarm state read wrong");
	enable_read_a: assert property (rd_en && addr == OFF_IRQ_ENABLES |=> rd_data == {3'h0, $past(en_reg)})
		else $error("enables read wrong");
	unmapped_read_a: assert property (rd_en && (addr < OFF_ALARM_STATE || addr > OFF_LINE_CONFIG) |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	// alarm causes
	loss_persist_a: assert property ($rose(alarm_state[BIT_FRAME_LOSS]) |-> low_reg >= LOW_MIN)
		else $error("frame loss declared too early");
	remote_sync_a: assert property ($rose(alarm_state[BIT_REMOTE]) |-> $past(frame_sync))
		else $error("remote alarm declared out of sync");
	e1_remote_a: assert property ($rose(alarm_state[BIT_E1_REMOTE]) |-> $past(e1_a_valid && e1_a_bit))
		else $error("e1 remote rose without a one bit");
	mf_remote_a: assert property ($rose(alarm_state[BIT_MF_REMOTE]) |-> $past(e1_y_valid && e1_y_bit))
		else $error("multiframe remote rose without a one bit");
	// main scenarios
	loss_seen_c: cover property ($rose(alarm_state[BIT_FRAME_LOSS]));
	blue_seen_c: cover property ($rose(alarm_state[BIT_BLUE]));
	irq_seen_c: cover property ($fell(irq_n));
endmodule

// ===== tb/line_framer_model.sv
`timescale 1ns/1ps
module line_framer_model (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// bench controls
	input  wire logic sync_on,
	input  wire logic mf_on,
	input  wire logic line_val,
	input  wire logic mon_val,
	// framer status
	output logic      frame_sync,
	output logic      cas_mf_sync,
	// bit streams
	output logic      rx_bit_valid,
	output logic      rx_bit,
	output logic      yel_bit_valid,
	output logic      yel_bit,
	output logic      e1_a_valid,
	output logic      e1_a_bit,
	output logic      e1_y_valid,
	output logic      e1_y_bit
);
	logic [1:0] div_reg;
	////////////////////////////////////////
	// sync levels and line bit every cycle
	assign frame_sync   = sync_on;
	assign cas_mf_sync  = mf_on;
	assign rx_bit_valid = reset_n;
	assign rx_bit       = line_val;
	// monitor bit every fourth cycle, inverted between pulses
	assign yel_bit_valid = (div_reg == 2'h3);
	assign yel_bit       = yel_bit_valid ? mon_val : ~mon_val;
	// divider for the monitor bit rate
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end
	// overhead bits idle low
	initial begin
		e1_a_valid = 1'b0;
		e1_a_bit   = 1'b0;
		e1_y_valid = 1'b0;
		e1_y_bit   = 1'b0;
	end
	// one a bit pulse, inverse value afterwards
	task automatic send_a(input logic v);
		e1_a_valid <= 1'b1;
		e1_a_bit   <= v;
		@(posedge core_clk);
		e1_a_valid <= 1'b0;
		e1_a_bit   <= ~v;
		@(posedge core_clk);
	endtask
	// one y bit pulse, inverse value afterwards
	task automatic send_y(input logic v);
		e1_y_valid <= 1'b1;
		e1_y_bit   <= v;
		@(posedge core_clk);
		e1_y_valid <= 1'b0;
		e1_y_bit   <= ~v;
		@(posedge core_clk);
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import line_alarm_pkg::*;
;
	logic       core_clk;
	logic       reset_n;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic       sync_on;
	logic       mf_on;
	logic       line_val;
	logic       mon_val;
	logic [7:0] rd_data;
	logic       frame_sync, cas_mf_sync, rx_bit_valid, rx_bit, yel_bit_valid, yel_bit;
	logic       e1_a_valid, e1_a_bit, e1_y_valid, e1_y_bit, irq_n;
	logic [4:0] alarm_state;
	int         fails    = 0;
	int         checks   = 0;
	////////////////////////////////////////
	// design with short windows, and its framer
	line_alarm_detector #(.WINDOW_LEN(64), .E1_LOSS_LEN(100)) dut (.core_clk, .reset_n, .addr, .wr_data,
		.wr_en, .rd_en, .rd_data, .frame_sync, .cas_mf_sync, .rx_bit_valid, .rx_bit, .yel_bit_valid,
		.yel_bit, .e1_a_valid, .e1_a_bit, .e1_y_valid, .e1_y_bit, .alarm_state, .irq_n);
	line_framer_model fm (.core_clk, .reset_n, .sync_on, .mf_on, .line_val, .mon_val, .frame_sync,
		.cas_mf_sync, .rx_bit_valid, .rx_bit, .yel_bit_valid, .yel_bit, .e1_a_valid, .e1_a_bit,
		.e1_y_valid, .e1_y_bit);
	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		chk("rd_data", e, rd_data);
		@(posedge core_clk);
	endtask
	// bounded wait for one alarm bit, then compare
	task automatic wait_state(input int b, input logic v, input int lim);
		int n;
		n = 0;
		#1;
		while (alarm_state[b] !== v && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("alarm_state", {7'h00, v}, {7'h00, alarm_state[b]});
		@(posedge core_clk);
	endtask
	task automatic chk_irq(input logic v);
		#1;
		chk("irq_n", {7'h00, v}, {7'h00, irq_n});
		@(posedge core_clk);
	endtask
	task automatic end_sim();
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		reset_n  <= 1'b0;
		wr_en    <= 1'b0;
		rd_en    <= 1'b0;
		addr     <= 8'h00;
		wr_data  <= 8'h00;
		sync_on  <= 1'b1;
		mf_on    <= 1'b0;
		line_val <= 1'b0;
		mon_val  <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		for (int a = OFF_FL_DECLARE; a <= OFF_BLUE_CLEAR; a++)
			rc(8'(a), RST_LIMIT);
		rc(OFF_LINE_CONFIG, 8'h00);
		wr(8'hc3, 8'hff);
		rc(8'hc3, 8'h00);
		wr(OFF_FL_CLEAR, 8'ha5);
		rc(OFF_FL_CLEAR, 8'ha5);
		wr(OFF_FL_CLEAR, 8'h01);
		wr(OFF_IRQ_ENABLES, 8'hff);
		rc(OFF_IRQ_ENABLES, 8'h1f);
		// slc-96 yellow, then clear through esf
		wait_state(BIT_REMOTE, 1'b1, 200);
		chk_irq(1'b0);
		rc(OFF_CHANGE_FLAGS, 8'h02);
		wr(OFF_CHANGE_FLAGS, 8'h1f);
		rc(OFF_CHANGE_FLAGS, 8'h00);
		chk_irq(1'b1);
		wr(OFF_LINE_CONFIG, 8'h02);
		wait_state(BIT_REMOTE, 1'b0, 200);
		// t1 frame loss with three windows
		wr(OFF_FL_DECLARE, 8'h03);
		sync_on <= 1'b0;
		repeat (150) @(posedge core_clk);
		wait_state(BIT_FRAME_LOSS, 1'b0, 0);
		wait_state(BIT_FRAME_LOSS, 1'b1, 150);
		sync_on <= 1'b1;
		wait_state(BIT_FRAME_LOSS, 1'b0, 200);
		// t1 blue, with older flags cleared first
		wr(OFF_CHANGE_FLAGS, 8'h1f);
		chk_irq(1'b1);
		line_val <= 1'b1;
		wait_state(BIT_BLUE, 1'b1, 200);
		chk_irq(1'b0);
		line_val <= 1'b0;
		wait_state(BIT_BLUE, 1'b0, 200);
		rc(OFF_CHANGE_FLAGS, 8'h04);
		// dm, j1 and data-link yellow verdicts
		mon_val <= 1'b0;
		wr(OFF_LINE_CONFIG, 8'h04);
		wait_state(BIT_REMOTE, 1'b1, 200);
		wr(OFF_LINE_CONFIG, 8'h06);
		wait_state(BIT_REMOTE, 1'b0, 200);
		mon_val <= 1'b1;
		wait_state(BIT_REMOTE, 1'b1, 200);
		wr(OFF_LINE_CONFIG, 8'h08);
		repeat (130) @(posedge core_clk);
		wait_state(BIT_REMOTE, 1'b1, 0);
		mon_val <= 1'b0;
		wait_state(BIT_REMOTE, 1'b0, 200);
		// e1 remote, both criteria, and multiframe remote
		wr(OFF_LINE_CONFIG, 8'h01);
		repeat (3) fm.send_a(1'b1);
		wait_state(BIT_E1_REMOTE, 1'b0, 0);
		fm.send_a(1'b1);
		wait_state(BIT_E1_REMOTE, 1'b1, 4);
		fm.send_a(1'b0);
		wait_state(BIT_E1_REMOTE, 1'b0, 4);
		wr(OFF_FL_DECLARE, 8'h01);
		fm.send_a(1'b1);
		wait_state(BIT_E1_REMOTE, 1'b1, 4);
		fm.send_a(1'b0);
		wait_state(BIT_E1_REMOTE, 1'b0, 4);
		mf_on <= 1'b1;
		repeat (2) fm.send_y(1'b1);
		wait_state(BIT_MF_REMOTE, 1'b0, 0);
		fm.send_y(1'b1);
		wait_state(BIT_MF_REMOTE, 1'b1, 4);
		fm.send_y(1'b0);
		wait_state(BIT_MF_REMOTE, 1'b0, 4);
		// e1 frame loss
		sync_on <= 1'b0;
		repeat (90) @(posedge core_clk);
		wait_state(BIT_FRAME_LOSS, 1'b0, 0);
		wait_state(BIT_FRAME_LOSS, 1'b1, 30);
		sync_on <= 1'b1;
		wait_state(BIT_FRAME_LOSS, 1'b0, 130);
		// e1 blue, two-window criteria then single window
		wr(OFF_FL_DECLARE, 8'h02);
		line_val <= 1'b1;
		wait_state(BIT_BLUE, 1'b1, 1600);
		line_val <= 1'b0;
		wait_state(BIT_BLUE, 1'b0, 1600);
		wr(OFF_FL_DECLARE, 8'h00);
		line_val <= 1'b1;
		repeat (1100) @(posedge core_clk);
		wait_state(BIT_BLUE, 1'b0, 0);
		sync_on <= 1'b0;
		wait_state(BIT_BLUE, 1'b1, 600);
		end_sim();
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		end_sim();
	end
endmodule

bind line_alarm_detector line_alarm_assertions #(.WINDOW_LEN(WINDOW_LEN), .E1_LOSS_LEN(E1_LOSS_LEN)) chk_i (
	.core_clk, .reset_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .frame_sync, .cas_mf_sync,
	.rx_bit_valid, .rx_bit, .yel_bit_valid, .yel_bit, .e1_a_valid, .e1_a_bit, .e1_y_valid, .e1_y_bit,
	.alarm_state, .irq_n);
